// file: verilog/cmd_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants and types for the disk command interpreter
// Assumes: One clock domain (pclk), APB register access
// Notes: Operation
//------------------------------------------------------------------------------
package cmd_pkg;
   //---------------------------------------------------------------------------
   // Operation codes and descriptor fields
   //---------------------------------------------------------------------------
   localparam logic [7:0] OP_SEEK = 8'h2b;
   localparam logic [7:0] OP_WRITE_VERIFY = 8'h2e;
   localparam logic [7:0] OP_VERIFY = 8'h2f;
   localparam logic [7:0] OP_READ_DEFECT = 8'h37;
   localparam int CACHE_HINT_BIT = 4;
   localparam int BYTE_CMP_BIT = 1;
   localparam int REL_ADDR_BIT = 0;
   localparam int PRIMARY_SEL_BIT = 4;
   localparam int GROWN_SEL_BIT = 3;
   localparam logic [2:0] FORMAT_PHYSICAL = 3'h5;
   localparam logic [16:0] HEADER_BYTES = 17'h00004;
   localparam logic [2:0] DESC_LAST_BYTE = 3'h7;
   localparam int DEFECT_IDX_W = 4;
   //---------------------------------------------------------------------------
   // Status and sense values
   //---------------------------------------------------------------------------
   localparam logic [7:0] STATUS_GOOD = 8'h00;
   localparam logic [7:0] STATUS_CHECK = 8'h02;
   localparam logic [3:0] SENSE_NONE = 4'h0;
   localparam logic [3:0] SENSE_MEDIUM_ERROR = 4'h3;
   localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_UNRECOVERED = 8'h11;
   localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
   localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
   //---------------------------------------------------------------------------
   // Register map (byte addresses) and reset value
   //---------------------------------------------------------------------------
   localparam logic [11:0] ADDR_CDB_LO = 12'h000;
   localparam logic [11:0] ADDR_CDB_MID = 12'h004;
   localparam logic [11:0] ADDR_CDB_HI = 12'h008;
   localparam logic [11:0] ADDR_CTRL = 12'h00c;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_HEAD_POS = 12'h014;
   localparam logic [11:0] ADDR_INT_STATUS = 12'h018;
   localparam logic [11:0] ADDR_INT_CLEAR = 12'h01c;
   localparam logic [11:0] ADDR_INT_ENABLE = 12'h020;
   localparam logic [11:0] ADDR_DEF_LO = 12'h024;
   localparam logic [11:0] ADDR_DEF_HI = 12'h028;
   localparam logic [11:0] ADDR_DEF_WRITE = 12'h02c;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int DEF_GROWN_BIT = 8;
   localparam int DEF_USED_BIT = 9;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_CHECK_BIT = 1;
   //---------------------------------------------------------------------------
   // Types
   //---------------------------------------------------------------------------
   typedef enum logic [1:0] {
      MED_SEEK = 2'h0,
      MED_WRITE_VERIFY = 2'h1,
      MED_VERIFY = 2'h2
   } medium_op_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_MEDIUM = 3'b011,
      ST_STREAM = 3'b010,
      ST_FINISH = 3'b110
   } cmd_state_type;
endpackage : cmd_pkg

// file: verilog/defect_if.sv
//------------------------------------------------------------------------------
// Purpose: Link between the command core and the defect list store
// Assumes: Both ends on pclk
// Notes: Read side is combinational inside the store
//------------------------------------------------------------------------------
`timescale 1ns/1ps
interface defect_if;
   import cmd_pkg::*;
   logic wr_en;
   logic [DEFECT_IDX_W-1:0] wr_idx;
   logic [63:0] wr_desc;
   logic wr_grown;
   logic wr_used;
   logic sel_primary;
   logic sel_grown;
   logic [DEFECT_IDX_W-1:0] rd_idx;
   logic [2:0] rd_pos;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [15:0] list_len;
   modport keeper(input wr_en, wr_idx, wr_desc, wr_grown, wr_used, sel_primary,
      sel_grown, rd_idx, rd_pos, output rd_byte, rd_hit, list_len);
   modport user(output wr_en, wr_idx, wr_desc, wr_grown, wr_used, sel_primary,
      sel_grown, rd_idx, rd_pos, input rd_byte, rd_hit, list_len);
endinterface : defect_if

// file: verilog/defect_list.sv
//------------------------------------------------------------------------------
// Purpose: Holds defect descriptors and serves them byte by byte
// Assumes: Software loads entries before issuing a defect read
// Notes: Used entries marked grown belong to the grown list, other used entries to primary
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module defect_list
   import cmd_pkg::*;
#(
   parameter int DEPTH = 1 << DEFECT_IDX_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core side
   defect_if.keeper dl
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [63:0] desc_mem [0:DEPTH-1];
   logic [DEPTH-1:0] grown;
   logic [DEPTH-1:0] used;
   logic [CW-1:0] sel_count;

   // Entry belongs to a requested list
   function automatic logic selected(input int i);
      selected = used[i] && (grown[i] ? dl.sel_grown : dl.sel_primary);
   endfunction : selected

   // Descriptor storage
   always_ff @(posedge pclk) begin
      if (dl.wr_en) begin
         desc_mem[dl.wr_idx] <= dl.wr_desc;
      end
   end

   // Entry flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grown <= '0;
         used <= '0;
      end else if (dl.wr_en) begin
         grown[dl.wr_idx] <= dl.wr_grown;
         used[dl.wr_idx] <= dl.wr_used;
      end
   end

   // Count of selected entries and list length
   always_comb begin
      sel_count = '0;
      for (int i = 0; i < DEPTH; i++) begin
         if (selected(i)) begin
            sel_count = sel_count + 1'b1;
         end
      end
      dl.list_len = 16'({sel_count, 3'b000});
   end

   // Byte of current entry, most significant first
   assign dl.rd_hit = selected(int'(dl.rd_idx));
   assign dl.rd_byte = 8'(desc_mem[dl.rd_idx] >> {DESC_LAST_BYTE - dl.rd_pos, 3'b000});
endmodule : defect_list

// file: verilog/disk_cmd_core.sv
//------------------------------------------------------------------------------
// Purpose: Decodes and runs seek, write-verify, verify and defect-read commands
// Assumes: Medium engine and host data paths run on pclk
// Notes: Software loads the descriptor block, then writes start
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module disk_cmd_core
   import cmd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Data to host (data-in phase)
   output logic [7:0] din_data,
   output logic din_valid,
   input wire logic din_ready,
   // Data from host (data-out phase)
   input wire logic [7:0] dout_data,
   input wire logic dout_valid,
   output logic dout_ready,
   // Medium engine
   output logic med_req,
   output medium_op_type med_op,
   output logic [31:0] med_lba,
   output logic [15:0] med_count,
   input wire logic med_done,
   input wire logic med_ecc_ok,
   output logic [7:0] med_wdata,
   output logic med_wvalid,
   input wire logic med_wready,
   // Interrupt
   output logic irq
);
   //---------------------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------------------
   defect_if dl();
   cmd_state_type state;
   logic [31:0] cdb_lo, cdb_mid;
   logic [15:0] cdb_hi;
   logic busy;
   logic [7:0] status_byte;
   logic [3:0] sense_key;
   logic [7:0] sense_asc;
   logic [31:0] head_pos;
   logic [1:0] int_status, int_enable;
   logic [31:0] def_lo, def_hi;
   logic [16:0] def_sent, def_limit;
   logic [DEFECT_IDX_W-1:0] def_idx;
   logic [2:0] def_pos;
   logic [3:0] next_sense;
   logic [7:0] next_asc;
   logic [7:0] opcode, byte1, byte2;
   logic [31:0] cdb_lba;
   logic [15:0] cdb_len;
   logic [16:0] total_bytes;
   logic setup, wr_take, start, writing, next_full, take_out, out_free;
   logic ev_done, ev_check;

   // Descriptor fields, byte 0 in the low lane
   assign opcode = cdb_lo[7:0];
   assign byte1 = cdb_lo[15:8];
   assign byte2 = cdb_lo[23:16];
   assign cdb_lba = {cdb_lo[23:16], cdb_lo[31:24], cdb_mid[7:0], cdb_mid[15:8]};
   assign cdb_len = {cdb_mid[31:24], cdb_hi[7:0]};

   //---------------------------------------------------------------------------
   // APB slave
   //---------------------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr_take = psel && penable && pready && pwrite;
   assign start = wr_take && paddr == ADDR_CTRL && pwdata[0] && !busy;

   function automatic logic mapped(input logic [11:0] a);
      mapped = a[1:0] == 2'b00 && a <= ADDR_DEF_WRITE;
   endfunction : mapped

   // Read view of registers
   function automatic logic [31:0] read_word(input logic [11:0] a);
      if (a == ADDR_CDB_LO) begin
         read_word = cdb_lo;
      end else if (a == ADDR_CDB_MID) begin
         read_word = cdb_mid;
      end else if (a == ADDR_CDB_HI) begin
         read_word = {16'h0000, cdb_hi};
      end else if (a == ADDR_STATUS) begin
         read_word = {sense_asc, 4'h0, sense_key, status_byte, 7'h00, busy};
      end else if (a == ADDR_HEAD_POS) begin
         read_word = head_pos;
      end else if (a == ADDR_INT_STATUS) begin
         read_word = {30'h0, int_status};
      end else if (a == ADDR_INT_ENABLE) begin
         read_word = {30'h0, int_enable};
      end else if (a == ADDR_DEF_LO) begin
         read_word = def_lo;
      end else if (a == ADDR_DEF_HI) begin
         read_word = def_hi;
      end else begin
         read_word = RESET_WORD;
      end
   endfunction : read_word

   // Zero wait state answer, read data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= RESET_WORD;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped(paddr);
         if (setup && !pwrite) begin
            prdata <= read_word(paddr);
         end
      end
   end

   // Software-written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cdb_lo <= RESET_WORD;
         cdb_mid <= RESET_WORD;
         cdb_hi <= 16'h0000;
         int_enable <= 2'h0;
         def_lo <= RESET_WORD;
         def_hi <= RESET_WORD;
      end else if (wr_take && !busy) begin
         if (paddr == ADDR_CDB_LO) begin
            cdb_lo <= pwdata;
         end else if (paddr == ADDR_CDB_MID) begin
            cdb_mid <= pwdata;
         end else if (paddr == ADDR_CDB_HI) begin
            cdb_hi <= pwdata[15:0];
         end else if (paddr == ADDR_INT_ENABLE) begin
            int_enable <= pwdata[1:0];
         end else if (paddr == ADDR_DEF_LO) begin
            def_lo <= pwdata;
         end else if (paddr == ADDR_DEF_HI) begin
            def_hi <= pwdata;
         end
      end else if (wr_take && paddr == ADDR_INT_ENABLE) begin
         int_enable <= pwdata[1:0];
      end
   end

   // Defect entry load pulse toward the store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dl.wr_en <= 1'b0;
         dl.wr_idx <= '0;
         dl.wr_grown <= 1'b0;
         dl.wr_used <= 1'b0;
      end else begin
         dl.wr_en <= wr_take && paddr == ADDR_DEF_WRITE && !busy;
         dl.wr_idx <= pwdata[DEFECT_IDX_W-1:0];
         dl.wr_grown <= pwdata[DEF_GROWN_BIT];
         dl.wr_used <= pwdata[DEF_USED_BIT];
      end
   end
   assign dl.wr_desc = {def_hi, def_lo};

   //---------------------------------------------------------------------------
   // Descriptor checks
   //---------------------------------------------------------------------------
   always_comb begin
      next_sense = SENSE_NONE;
      next_asc = ASC_NONE;
      case (opcode)
         OP_SEEK: begin
            next_sense = SENSE_NONE;
         end
         OP_WRITE_VERIFY, OP_VERIFY: begin
            if (byte1[CACHE_HINT_BIT] || byte1[BYTE_CMP_BIT] || byte1[REL_ADDR_BIT]) begin
               next_sense = SENSE_ILLEGAL;
               next_asc = ASC_BAD_FIELD;
            end
         end
         OP_READ_DEFECT: begin
            if (byte2[2:0] != FORMAT_PHYSICAL) begin
               next_sense = SENSE_ILLEGAL;
               next_asc = ASC_BAD_FIELD;
            end
         end
         default: begin
            next_sense = SENSE_ILLEGAL;
            next_asc = ASC_BAD_OPCODE;
         end
      endcase
   end

   // Selects from byte 2, bytes available, transfer limit
   assign dl.sel_primary = byte2[PRIMARY_SEL_BIT];
   assign dl.sel_grown = byte2[GROWN_SEL_BIT];
   assign total_bytes = HEADER_BYTES + 17'(dl.list_len);

   //---------------------------------------------------------------------------
   // Command sequencer
   //---------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         busy <= 1'b0;
         status_byte <= STATUS_GOOD;
         sense_key <= SENSE_NONE;
         sense_asc <= ASC_NONE;
         med_req <= 1'b0;
         med_op <= MED_SEEK;
         med_lba <= RESET_WORD;
         med_count <= 16'h0000;
         head_pos <= RESET_WORD;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_DECODE;
                  busy <= 1'b1;
               end
            end
            ST_DECODE: begin
               sense_key <= next_sense;
               sense_asc <= next_asc;
               med_lba <= cdb_lba;
               med_count <= cdb_len;
               if (next_sense != SENSE_NONE) begin
                  status_byte <= STATUS_CHECK;
                  state <= ST_FINISH;
               end else if (opcode == OP_READ_DEFECT) begin
                  status_byte <= STATUS_GOOD;
                  state <= ST_STREAM;
               end else if (opcode != OP_SEEK && cdb_len == 16'h0000) begin
                  status_byte <= STATUS_GOOD;
                  state <= ST_FINISH;
               end else begin
                  med_req <= 1'b1;
                  med_op <= opcode == OP_SEEK ? MED_SEEK :
                     opcode == OP_WRITE_VERIFY ? MED_WRITE_VERIFY : MED_VERIFY;
                  state <= ST_MEDIUM;
               end
            end
            ST_MEDIUM: begin
               if (med_done) begin
                  med_req <= 1'b0;
                  state <= ST_FINISH;
                  if (med_op == MED_SEEK) begin
                     head_pos <= med_lba;
                     status_byte <= STATUS_GOOD;
                  end else if (med_ecc_ok) begin
                     status_byte <= STATUS_GOOD;
                  end else begin
                     status_byte <= STATUS_CHECK;
                     sense_key <= SENSE_MEDIUM_ERROR;
                     sense_asc <= ASC_UNRECOVERED;
                  end
               end
            end
            ST_STREAM: begin
               if (def_sent == def_limit && !din_valid) begin
                  state <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Host data-out to medium, one holding byte, sent once
   //---------------------------------------------------------------------------
   assign writing = state == ST_MEDIUM && med_op == MED_WRITE_VERIFY;
   assign take_out = dout_valid && dout_ready;
   assign next_full = take_out || (med_wvalid && !med_wready);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         med_wdata <= 8'h00;
         med_wvalid <= 1'b0;
         dout_ready <= 1'b0;
      end else begin
         dout_ready <= writing && !med_done && !next_full;
         if (take_out) begin
            med_wdata <= dout_data;
            med_wvalid <= 1'b1;
         end else if (med_wready) begin
            med_wvalid <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Defect data-in stream
   //---------------------------------------------------------------------------
   assign out_free = !din_valid || din_ready;
   assign dl.rd_idx = def_idx;
   assign dl.rd_pos = def_pos;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         def_sent <= 17'h00000;
         def_limit <= 17'h00000;
         def_idx <= '0;
         def_pos <= 3'h0;
         din_data <= 8'h00;
         din_valid <= 1'b0;
      end else if (state == ST_DECODE) begin
         def_sent <= 17'h00000;
         def_idx <= '0;
         def_pos <= 3'h0;
         def_limit <= 17'(cdb_len) < total_bytes ? 17'(cdb_len) : total_bytes;
      end else if (state == ST_STREAM && out_free) begin
         din_valid <= 1'b0;
         if (def_sent == def_limit) begin
            din_valid <= 1'b0;
         end else if (def_sent < HEADER_BYTES) begin
            din_valid <= 1'b1;
            def_sent <= def_sent + 17'h00001;
            case (def_sent[1:0])
               2'h0: din_data <= 8'h00;
               2'h1: din_data <= {3'h0, dl.sel_primary, dl.sel_grown, byte2[2:0]};
               2'h2: din_data <= dl.list_len[15:8];
               default: din_data <= dl.list_len[7:0];
            endcase
         end else if (!dl.rd_hit) begin
            def_idx <= def_idx + 1'b1;
         end else begin
            din_valid <= 1'b1;
            din_data <= dl.rd_byte;
            def_sent <= def_sent + 17'h00001;
            def_pos <= def_pos + 3'h1;
            if (def_pos == DESC_LAST_BYTE) begin
               def_idx <= def_idx + 1'b1;
            end
         end
      end else if (din_ready) begin
         din_valid <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Interrupts, set wins over clear
   //---------------------------------------------------------------------------
   assign ev_done = state == ST_FINISH;
   assign ev_check = ev_done && status_byte == STATUS_CHECK;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= 2'h0;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == IRQ_DONE_BIT && ev_done) || (i == IRQ_CHECK_BIT && ev_check)) begin
               int_status[i] <= 1'b1;
            end else if (wr_take && paddr == ADDR_INT_CLEAR && pwdata[i]) begin
               int_status[i] <= 1'b0;
            end
         end
         irq <= |(int_status & int_enable);
      end
   end

   //---------------------------------------------------------------------------
   // Defect list store
   //---------------------------------------------------------------------------
   defect_list u_defect_list (
      .pclk(pclk),
      .presetn(presetn),
      .dl(dl)
   );
endmodule : disk_cmd_core

// file: bench/cmd_chk_assertions.sv
// Purpose: Port-level checks of the disk command interpreter
// Assumes: Bound to disk_cmd_core, one clock domain
// Notes: Covers mark the main traffic kinds
`timescale 1ns/1ps
module cmd_chk
   import cmd_pkg::*;
(
   // Watched ports
   input wire logic pclk, presetn, psel, penable, pready, pslverr, irq,
   input wire logic din_valid, din_ready, dout_ready, med_req, med_done, med_wvalid, med_wready,
   input wire logic [11:0] paddr,
   input wire logic [7:0] din_data, med_wdata,
   input wire logic [31:0] med_lba,
   input medium_op_type med_op
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer timing and error flag
   a_apb_answer: assert property (psel && !penable |=> pready) else $error("no pready");
   a_apb_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_apb_error: assert property (pready |-> pslverr == (paddr > ADDR_DEF_WRITE
      || paddr[1:0] != 2'h0)) else $error("bad pslverr");
   // Medium request and data streams
   a_lba_steady: assert property (med_req && !med_done |=> med_req && $stable(med_lba))
      else $error("medium request dropped");
   a_req_ends: assert property (med_req && med_done |=> !med_req) else $error("req stuck");
   a_wdata_hold: assert property (med_wvalid && !med_wready |=> med_wvalid && $stable(med_wdata))
      else $error("medium byte lost");
   a_host_once: assert property (dout_ready |-> med_req && med_op == MED_WRITE_VERIFY)
      else $error("host data asked outside write");
   a_din_hold: assert property (din_valid && !din_ready |=> din_valid && $stable(din_data))
      else $error("defect byte lost");
   a_din_alone: assert property (din_valid |-> !med_req) else $error("defect data mid medium");
   c_defect: cover property (din_valid && din_ready);
   c_write: cover property (med_wvalid && med_wready);
   c_irq: cover property ($rose(irq));
endmodule : cmd_chk
bind disk_cmd_core cmd_chk u_chk (.*);

// file: bench/medium_model.sv
// Purpose: Medium engine on the far side of the interpreter
// Assumes: One pclk domain
// Notes: Ready every other cycle; ecc_bad forces a failed check
`timescale 1ns/1ps
module medium_model
   import cmd_pkg::*;
(
   // Clock, reset and fault control
   input wire logic pclk, presetn, ecc_bad,
   // Medium engine port
   input wire logic med_req, med_wvalid,
   input wire logic [15:0] med_count,
   input medium_op_type med_op,
   output logic med_done, med_ecc_ok, med_wready
);
   logic [24:0] got;
   // Take 512 bytes per block on write-verify, then end the operation; other operations end at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got <= '0;
         med_done <= 1'b0;
         med_wready <= 1'b0;
      end else begin
         med_wready <= med_req && !med_wready;
         if (med_wvalid && med_wready) got <= got + 25'h1;
         med_done <= med_req && !med_done && (med_op != MED_WRITE_VERIFY
            || got == {med_count, 9'h0});
         if (med_done) got <= '0;
      end
   end
   assign med_ecc_ok = !ecc_bad;
endmodule : medium_model

// file: bench/disk_seek_verify_defect_cmds_tb.sv
// Purpose: Self-checking bench of the command interpreter
// Assumes: APB master in this bench, medium model on the far side
// Notes: Host data-in ready stalls every other cycle
`timescale 1ns/1ps
module disk_seek_verify_defect_cmds_tb;
   import cmd_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, med_lba;
   logic [7:0] din_data, dout_data = 0, med_wdata, rx[$], fl[3] = '{8'h10, 8'h02, 8'h01};
   logic din_valid, din_ready = 0, dout_valid = 0, dout_ready, med_req, med_done, med_ecc_ok;
   logic med_wvalid, med_wready, ecc_bad = 0, wv_on = 0, last_err;
   logic [15:0] med_count;
   medium_op_type med_op;
   int miscompares = 0, cmp_count = 0, sent = 0, taken = 0;
   disk_cmd_core u_dut (.*);
   medium_model u_med (.*);
   always #50 pclk = !pclk;
   // Host streams and byte counts
   always @(posedge pclk) begin
      din_ready <= !din_ready;
      if (din_valid && din_ready) rx.push_back(din_data);
      if (dout_valid && dout_ready) sent <= sent + 1;
      if (med_wvalid && med_wready) taken <= taken + 1;
      dout_valid <= wv_on && sent + int'(dout_valid && dout_ready) < 512;
      dout_data <= 8'(sent + int'(dout_valid && dout_ready));
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic chkq(input logic [7:0] e[$]);
      chk(rx.size(), e.size());
      foreach (e[i]) chk({24'h0, rx[i]}, {24'h0, e[i]});
   endtask : chkq
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (n = 0; n < 9 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 9) begin miscompares++; wrap_up; end
      r = prdata; last_err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   function automatic logic [31:0] sw(logic [3:0] k, logic [7:0] a);
      return {a, 4'h0, k, k == SENSE_NONE ? STATUS_GOOD : STATUS_CHECK, 8'h00};
   endfunction : sw
   task automatic cmd(input logic [31:0] lo, mid, hi, st);
      logic [31:0] r;
      int n;
      apb(1, ADDR_CDB_LO, lo, r); apb(1, ADDR_CDB_MID, mid, r); apb(1, ADDR_CDB_HI, hi, r);
      rx.delete();
      apb(1, ADDR_CTRL, 32'h1, r);
      n = 0;
      do begin apb(0, ADDR_STATUS, 0, r); n++; end while (r[0] !== 1'b0 && n < 3000);
      if (r[0] !== 1'b0) begin miscompares++; wrap_up; end
      chk(r, st);
   endtask : cmd
   task automatic t_regs;
      logic [31:0] r;
      apb(0, ADDR_STATUS, 0, r); chk(r, RESET_WORD);
      apb(0, 12'h030, 0, r); chk({r[31:1], last_err}, 32'h1);
   endtask : t_regs
   task automatic t_seek;
      logic [31:0] r;
      apb(1, ADDR_INT_ENABLE, 32'h2, r);
      cmd(32'h3412002b, 32'h00007856, 0, 0); chk(irq, 0);
      apb(0, ADDR_HEAD_POS, 0, r); chk(r, 32'h12345678);
      apb(0, ADDR_INT_STATUS, 0, r); chk(r, 32'h1);
      apb(1, ADDR_INT_ENABLE, 32'h1, r); apb(0, ADDR_INT_STATUS, 0, r); chk(irq, 1);
      apb(1, ADDR_INT_CLEAR, 32'h3, r); apb(0, ADDR_INT_STATUS, 0, r); chk({r[31:1], irq}, 0);
   endtask : t_seek
   task automatic t_wv;
      wv_on <= 1;
      cmd(32'h0000002e, 0, 32'h1, 0);
      chk(sent, 512); chk(taken, 512);
      cmd(32'h0000002e, 0, 0, 0); chk(taken, 512);
      wv_on <= 0;
   endtask : t_wv
   task automatic t_verify;
      ecc_bad <= 1;
      cmd(32'h0000002f, 0, 32'h1, sw(SENSE_MEDIUM_ERROR, ASC_UNRECOVERED));
      ecc_bad <= 0;
      cmd(32'h0000002f, 0, 32'h1, 0);
      cmd(32'h0000002f, 0, 0, 0);
      for (int i = 0; i < 6; i++) cmd({16'h0, fl[i % 3], i < 3 ? OP_VERIFY : OP_WRITE_VERIFY},
         0, 1, sw(SENSE_ILLEGAL, ASC_BAD_FIELD));
      cmd(32'h00000099, 0, 0, sw(SENSE_ILLEGAL, ASC_BAD_OPCODE));
   endtask : t_verify
   task automatic t_defect;
      logic [31:0] r;
      apb(1, ADDR_DEF_LO, 32'h11223344, r); apb(1, ADDR_DEF_HI, 32'h0a0b0c01, r);
      apb(1, ADDR_DEF_WRITE, 32'h200, r);
      apb(1, ADDR_DEF_LO, 32'h55667788, r); apb(1, ADDR_DEF_HI, 32'h00010202, r);
      apb(1, ADDR_DEF_WRITE, 32'h301, r);
      cmd(32'h001d0037, 0, 32'h0a, 0);
      chkq('{8'h00, 8'h1d, 8'h00, 8'h10, 8'h0a, 8'h0b, 8'h0c, 8'h01, 8'h11, 8'h22});
      chk(32'(rx[3]) >> 3, 2); chk(32'(rx[3]) + 4 > 10, 1);
      cmd(32'h000d0037, 0, 32'h40, 0);
      chkq('{8'h00, 8'h0d, 8'h00, 8'h08, 8'h00, 8'h01, 8'h02, 8'h02,
         8'h55, 8'h66, 8'h77, 8'h88});
      cmd(32'h00150037, 0, 0, 0); chk(rx.size(), 0);
      cmd(32'h00050037, 0, 32'h40, 0); chkq('{8'h00, 8'h05, 8'h00, 8'h00});
      cmd(32'h001c0037, 0, 32'h40, sw(SENSE_ILLEGAL, ASC_BAD_FIELD));
   endtask : t_defect
   // Reset, then scenarios
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_regs; t_seek; t_wv; t_verify; t_defect;
      wrap_up;
   end
endmodule : disk_seek_verify_defect_cmds_tb
